// ### verilog/synth_prog_pkg.sv
// Purpose: Constants for the synthesizer programming host controller.
// Assumes: 10 MHz system clock; serial clock made by a divider.
// Notes:   Words shift most significant bit first.
// Overview of operation
// - User picks prescaler keeping output within limit.
// - Latch method: function(reset 0), reference, N.
// - Enable method: enable low, three writes, raise.
// - Wait one microsecond after raising enable.
// - Reset method: function(1), reference, N, function(0).
// - Serial clock never faster than 20 MHz.
// - Load low, three bytes, then load high.
// - Data valid before first (rising) clock edge.
// - Output inactive until all three latches written.
// - Enable from output pin; lock status polled.
package synth_prog_pkg;
	localparam int          WORD_BITS       = 24;
	localparam int          BYTE_BITS       = 8;
	localparam logic [1:0]  SEL_REFERENCE   = 2'h0;
	localparam logic [1:0]  SEL_N_COUNTER   = 2'h1;
	localparam logic [1:0]  SEL_FUNCTION    = 2'h2;
	localparam int          CTRL_LO_POS     = 0;
	localparam int          COUNTER_RST_POS = 2;
	localparam int          PRI_CP_LSB_POS  = 15;
	localparam int          SEC_CP_LSB_POS  = 18;
	localparam int          PD_POL_POS      = 7;
	localparam int          CP_TRI_POS      = 8;
	localparam int          PRESCALER_POS   = 22;
	localparam int          CLK_MHZ         = 10;
	localparam int          SCLK_MAX_MHZ    = 20;
	localparam int          SCLK_HALF_CYC   = 4;
	localparam int          SETTLE_NS       = 1000;
	localparam int          CLK_PERIOD_NS   = 1000 / CLK_MHZ;
	localparam int          SETTLE_CYC      = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [1:0]  METHOD_LATCH    = 2'h0;
	localparam logic [1:0]  METHOD_ENABLE   = 2'h1;
	localparam logic [1:0]  METHOD_RESET    = 2'h2;
endpackage : synth_prog_pkg

// ### verilog/serial_word_shifter.sv
// Purpose: Shifts one 24-bit word out on clock, data and load pins.
// Assumes: One system clock; serial clock is a divided enable.
// Notes:   Load drops before the first bit and rises after the last.
`timescale 1ns/10ps
`default_nettype none
module serial_word_shifter
	import synth_prog_pkg::*;
#(
	parameter int HALF_CYC = SCLK_HALF_CYC
) (
	input  wire logic                 clock,
	input  wire logic                 rst_n,
	input  wire logic                 start,
	input  wire logic [WORD_BITS-1:0] word,
	output logic                      busy,
	output logic                      done,
	output logic                      serial_clock,
	output logic                      serial_data,
	output logic                      load_enable
);
	initial begin
		if (HALF_CYC < 1 || HALF_CYC > 256 || 1000 / (2 * HALF_CYC * CLK_PERIOD_NS) > SCLK_MAX_MHZ) begin
			$error("serial_word_shifter: HALF_CYC out of range");
		end
	end

	typedef enum logic [1:0] {
		SH_IDLE  = 2'b00,
		SH_LOW   = 2'b01,
		SH_HIGH  = 2'b10,
		SH_LOAD  = 2'b11
	} shift_state_e;

	shift_state_e           state_r, state_nxt;
	logic [WORD_BITS-1:0]   sreg_r, sreg_nxt;
	logic [4:0]             bits_r, bits_nxt;
	logic [7:0]             div_r, div_nxt;
	logic                   sck_r, sck_nxt;
	logic                   le_r, le_nxt;
	logic                   done_r, done_nxt;
	logic                   tick;

	assign tick = (div_r == 8'(HALF_CYC - 1));

	always_comb begin
		state_nxt = state_r;
		sreg_nxt  = sreg_r;
		bits_nxt  = bits_r;
		div_nxt   = tick ? 8'h00 : div_r + 8'h01;
		sck_nxt   = sck_r;
		le_nxt    = le_r;
		done_nxt  = 1'b0;
		unique case (state_r)
			SH_IDLE: begin
				div_nxt = 8'h00;
				if (start) begin
					sreg_nxt  = word;
					bits_nxt  = 5'h00;
					le_nxt    = 1'b0;
					state_nxt = SH_LOW;
				end
			end
			SH_LOW: begin
				if (tick) begin
					sck_nxt   = 1'b1;
					state_nxt = SH_HIGH;
				end
			end
			SH_HIGH: begin
				if (tick) begin
					sck_nxt  = 1'b0;
					sreg_nxt = {sreg_r[WORD_BITS-2:0], 1'b0};
					bits_nxt = bits_r + 5'h01;
					if (bits_r == 5'(WORD_BITS - 1)) begin
						state_nxt = SH_LOAD;
					end else begin
						state_nxt = SH_LOW;
					end
				end
			end
			SH_LOAD: begin
				if (tick) begin
					le_nxt    = 1'b1;
					done_nxt  = 1'b1;
					state_nxt = SH_IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			state_r <= SH_IDLE;
			sreg_r  <= '0;
			bits_r  <= 5'h00;
			div_r   <= 8'h00;
			sck_r   <= 1'b0;
			le_r    <= 1'b1;
			done_r  <= 1'b0;
		end else begin
			state_r <= state_nxt;
			sreg_r  <= sreg_nxt;
			bits_r  <= bits_nxt;
			div_r   <= div_nxt;
			sck_r   <= sck_nxt;
			le_r    <= le_nxt;
			done_r  <= done_nxt;
		end
	end

	assign busy         = (state_r != SH_IDLE);
	assign done         = done_r;
	assign serial_clock = sck_r;
	assign serial_data  = sreg_r[WORD_BITS-1];
	assign load_enable  = le_r;

	a_load_after_word: assert property (@(posedge clock) disable iff (!rst_n)
		$rose(le_r) |-> $past(bits_r) == 5'(WORD_BITS))
		else $error("load rose before all bits were sent");
	a_data_stable_high: assert property (@(posedge clock) disable iff (!rst_n)
		sck_r && $past(sck_r) |-> $stable(sreg_r[WORD_BITS-1]))
		else $error("data changed while serial clock high");
	a_clock_idle_load: assert property (@(posedge clock) disable iff (!rst_n)
		le_r |-> !sck_r)
		else $error("serial clock pulsed outside a frame");
endmodule : serial_word_shifter
`default_nettype wire

// ### verilog/synth_prog_host.sv
// Purpose: Host controller that programs the synthesizer latches.
// Assumes: User gives the three words; pins driven as plain outputs.
// Notes:   Runs one of three power-up methods or single latch writes.
`timescale 1ns/10ps
`default_nettype none
module synth_prog_host
	import synth_prog_pkg::*;
#(
	parameter int HALF_CYC = SCLK_HALF_CYC,
	parameter int SETTLE   = SETTLE_CYC
) (
	input  wire logic                 clock,
	input  wire logic                 rst_n,
	input  wire logic                 init_start,
	input  wire logic [1:0]           init_method,
	input  wire logic [WORD_BITS-1:0] function_word,
	input  wire logic [WORD_BITS-1:0] reference_word,
	input  wire logic [WORD_BITS-1:0] n_counter_word,
	input  wire logic                 single_start,
	input  wire logic [WORD_BITS-1:0] single_word,
	input  wire logic                 power_down_req,
	input  wire logic                 muxed_status_output,
	output logic                      busy,
	output logic                      init_done,
	output logic                      lock_detect,
	output logic                      serial_clock,
	output logic                      serial_data,
	output logic                      load_enable,
	output logic                      chip_enable
);
	initial begin
		if (SETTLE < 1) begin
			$error("synth_prog_host: SETTLE must be at least one cycle");
		end
		if (SETTLE > 65536) begin
			$error("synth_prog_host: SETTLE does not fit the settle counter");
		end
		if (HALF_CYC < 1 || HALF_CYC > 256) begin
			$error("synth_prog_host: HALF_CYC out of range");
		end
	end

	////////////////////////////////////////////////////////////////////////////////////////////////

	typedef enum logic [3:0] {
		ST_IDLE    = 4'h0,
		ST_FUNC    = 4'h1,
		ST_REF     = 4'h2,
		ST_NCNT    = 4'h3,
		ST_FUNC2   = 4'h4,
		ST_SETTLE  = 4'h5,
		ST_SINGLE  = 4'h6,
		ST_WAIT    = 4'h7
	} host_state_e;

	function automatic logic [WORD_BITS-1:0] route(input logic [WORD_BITS-1:0] w, input logic [1:0] sel);
		route = {w[WORD_BITS-1:2], sel};
	endfunction : route

	function automatic logic [WORD_BITS-1:0] set_reset(input logic [WORD_BITS-1:0] w, input logic v);
		set_reset = w;
		set_reset[COUNTER_RST_POS] = v;
	endfunction : set_reset

	host_state_e            state_r, state_nxt, after_r, after_nxt;
	logic [1:0]             method_r, method_nxt;
	logic                   ce_r, ce_nxt;
	logic                   done_r, done_nxt;
	logic [15:0]            cnt_r, cnt_nxt;
	logic                   go;
	logic [WORD_BITS-1:0]   word;
	logic                   sh_busy;
	logic                   sh_done;
	logic                   stat_meta_r, stat_meta_nxt;
	logic                   stat_sync_r, stat_sync_nxt;
	logic [2:0]             loads_r, loads_nxt;

	// Chooses the word for the latch about to be written.
	always_comb begin
		word = route(function_word, SEL_FUNCTION);
		unique case (state_r)
			ST_FUNC:   word = set_reset(route(function_word, SEL_FUNCTION),
						method_r == METHOD_RESET);
			ST_REF:    word = route(reference_word, SEL_REFERENCE);
			ST_NCNT:   word = route(n_counter_word, SEL_N_COUNTER);
			ST_FUNC2:  word = set_reset(route(function_word, SEL_FUNCTION), 1'b0);
			ST_SINGLE: word = single_word;
			default:   word = route(function_word, SEL_FUNCTION);
		endcase
	end

	always_comb begin
		state_nxt  = state_r;
		after_nxt  = after_r;
		method_nxt = method_r;
		ce_nxt     = ce_r;
		done_nxt   = done_r;
		cnt_nxt    = cnt_r;
		go         = 1'b0;
		unique case (state_r)
			ST_IDLE: begin
				ce_nxt = !power_down_req;
				if (init_start) begin
					method_nxt = init_method;
					done_nxt   = 1'b0;
					if (init_method == METHOD_ENABLE) begin
						ce_nxt = 1'b0;
					end
					state_nxt = ST_FUNC;
				end else if (single_start) begin
					state_nxt = ST_SINGLE;
				end
			end
			ST_FUNC, ST_REF, ST_NCNT, ST_FUNC2, ST_SINGLE: begin
				go = !sh_busy;
				if (!sh_busy) begin
					unique case (state_r)
						ST_FUNC:  after_nxt = ST_REF;
						ST_REF:   after_nxt = ST_NCNT;
						ST_NCNT:  after_nxt = (method_r == METHOD_RESET) ? ST_FUNC2 : ST_SETTLE;
						ST_FUNC2: after_nxt = ST_SETTLE;
						default:  after_nxt = ST_IDLE;
					endcase
					state_nxt = ST_WAIT;
				end
			end
			ST_WAIT: begin
				if (sh_done) begin
					state_nxt = after_r;
					cnt_nxt   = 16'h0000;
					if (after_r == ST_SETTLE) begin
						ce_nxt = 1'b1;
					end
				end
			end
			ST_SETTLE: begin
				cnt_nxt = cnt_r + 16'h0001;
				if (cnt_r == 16'(SETTLE - 1)) begin
					done_nxt  = 1'b1;
					state_nxt = ST_IDLE;
				end
			end
			default: begin
				state_nxt = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			state_r     <= ST_IDLE;
			after_r     <= ST_IDLE;
			method_r    <= METHOD_LATCH;
			ce_r        <= 1'b0;
			done_r      <= 1'b0;
			cnt_r       <= 16'h0000;
		end else begin
			state_r     <= state_nxt;
			after_r     <= after_nxt;
			method_r    <= method_nxt;
			ce_r        <= ce_nxt;
			done_r      <= done_nxt;
			cnt_r       <= cnt_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////////////////////////

	// The status pin is asynchronous, so only the second flip-flop feeds any logic.
	always_comb begin
		stat_meta_nxt = muxed_status_output;
		stat_sync_nxt = stat_meta_r;
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			stat_meta_r <= 1'b0;
			stat_sync_r <= 1'b0;
		end else begin
			stat_meta_r <= stat_meta_nxt;
			stat_sync_r <= stat_sync_nxt;
		end
	end

	// Counts the latch loads of the running power-up pass so the checks can see how many were made.
	always_comb begin
		loads_nxt = loads_r;
		if (state_r == ST_IDLE && init_start) begin
			loads_nxt = 3'h0;
		end else if (sh_done && after_r != ST_IDLE && loads_r != 3'h7) begin
			loads_nxt = loads_r + 3'h1;
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			loads_r <= 3'h0;
		end else begin
			loads_r <= loads_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////////////////////////

	serial_word_shifter #(
		.HALF_CYC     (HALF_CYC)
	) u_shift (
		.clock        (clock),
		.rst_n        (rst_n),
		.start        (go),
		.word         (word),
		.busy         (sh_busy),
		.done         (sh_done),
		.serial_clock (serial_clock),
		.serial_data  (serial_data),
		.load_enable  (load_enable)
	);

	assign busy        = (state_r != ST_IDLE);
	assign init_done   = done_r;
	assign lock_detect = stat_sync_r;
	assign chip_enable = ce_r;

	////////////////////////////////////////////////////////////////////////////////////////////////

	a_ce_low_during: assert property (@(posedge clock) disable iff (!rst_n)
		(method_r == METHOD_ENABLE) && (state_r inside {ST_FUNC, ST_REF, ST_NCNT}) |-> !ce_r)
		else $error("chip enable high during enable-method writes");
	a_reset_bit_first: assert property (@(posedge clock) disable iff (!rst_n)
		go && state_r == ST_FUNC |-> word[COUNTER_RST_POS] == (method_r == METHOD_RESET))
		else $error("counter reset bit wrong in first function write");
	a_reset_bit_clear: assert property (@(posedge clock) disable iff (!rst_n)
		go && state_r == ST_FUNC2 |-> !word[COUNTER_RST_POS] && word[1:0] == SEL_FUNCTION)
		else $error("final function write does not clear counter reset");
	a_route_ref: assert property (@(posedge clock) disable iff (!rst_n)
		go && state_r == ST_REF |-> word[1:0] == SEL_REFERENCE)
		else $error("reference word has wrong control bits");
	a_route_n: assert property (@(posedge clock) disable iff (!rst_n)
		go && state_r == ST_NCNT |-> word[1:0] == SEL_N_COUNTER)
		else $error("N word has wrong control bits");
	a_settle_wait: assert property (@(posedge clock) disable iff (!rst_n)
		$rose(done_r) |-> $past(state_r) == ST_SETTLE && $past(cnt_r) == 16'(SETTLE - 1))
		else $error("done raised before settle time");
	a_done_after_ce: assert property (@(posedge clock) disable iff (!rst_n)
		$rose(done_r) |-> ce_r && $past(state_r) == ST_SETTLE)
		else $error("init done without all writes and enable");
	a_pd_follow: assert property (@(posedge clock) disable iff (!rst_n)
		state_r == ST_IDLE && !init_start |=> ce_r == !$past(power_down_req))
		else $error("chip enable does not follow power-down request");

	// Checks across the power-up pass, single writes, the idle link and the lock synchronizer.
	sequence s_last_load;
		state_r == ST_WAIT && sh_done && after_r == ST_SETTLE;
	endsequence
	sequence s_settle_entry;
		state_r == ST_SETTLE && cnt_r == 16'h0000;
	endsequence
	a_settle_entry: assert property (@(posedge clock) disable iff (!rst_n)
		s_last_load |=> s_settle_entry)
		else $error("settle count did not start at the last load");
	a_ce_up_settle: assert property (@(posedge clock) disable iff (!rst_n)
		s_last_load |=> ce_r)
		else $error("chip enable not raised after the last load");
	a_ce_rise_last: assert property (@(posedge clock) disable iff (!rst_n)
		$rose(ce_r) && $past(state_r) != ST_IDLE |-> state_r == ST_SETTLE)
		else $error("chip enable rose in the middle of a sequence");
	a_ce_low_wait: assert property (@(posedge clock) disable iff (!rst_n)
		method_r == METHOD_ENABLE && state_r == ST_WAIT && after_r != ST_SETTLE |-> !ce_r)
		else $error("chip enable high between enable-method writes");
	a_route_func: assert property (@(posedge clock) disable iff (!rst_n)
		go && state_r == ST_FUNC |-> word[1:0] == SEL_FUNCTION)
		else $error("function word has wrong control bits");
	a_single_as_is: assert property (@(posedge clock) disable iff (!rst_n)
		go && state_r == ST_SINGLE |-> word == single_word)
		else $error("single word altered");
	a_idle_quiet: assert property (@(posedge clock) disable iff (!rst_n)
		!busy |-> load_enable && !serial_clock)
		else $error("link not quiet while idle");
	a_one_go: assert property (@(posedge clock) disable iff (!rst_n)
		go |=> !go)
		else $error("two word starts in a row");
	a_method_held: assert property (@(posedge clock) disable iff (!rst_n)
		busy && $past(busy) |-> $stable(method_r))
		else $error("method changed during a sequence");
	a_done_clear: assert property (@(posedge clock) disable iff (!rst_n)
		state_r == ST_IDLE && init_start |=> !init_done)
		else $error("init done not cleared at start");
	a_lock_two_flop: assert property (@(posedge clock) disable iff (!rst_n)
		$past(rst_n, 2) |-> lock_detect == $past(muxed_status_output, 2))
		else $error("lock status not passed through two flip-flops");
	a_loads_at_done: assert property (@(posedge clock) disable iff (!rst_n)
		$rose(done_r) |-> loads_r == ((method_r == METHOD_RESET) ? 3'h4 : 3'h3))
		else $error("wrong number of latch loads before init done");
	a_loads_ce_enable: assert property (@(posedge clock) disable iff (!rst_n)
		method_r == METHOD_ENABLE && busy && loads_r < 3'h3 |-> !ce_r)
		else $error("chip enable high before all three loads");
endmodule : synth_prog_host
`default_nettype wire

// ### sim/synth_device_model.sv
// Purpose: Behavioural synthesizer programming port for the bench.
// Assumes: Pins are driven by the host controller.
// Notes:   Every latch load is logged with the enable level.
`timescale 1ns/10ps
`default_nettype none
module synth_device_model
	import synth_prog_pkg::*;
(
	input  wire logic serial_clock,
	input  wire logic serial_data,
	input  wire logic load_enable,
	input  wire logic chip_enable,
	output logic      muxed_status_output
);
	logic [WORD_BITS-1:0] shift_r;
	logic [WORD_BITS-1:0] func_r;
	logic [WORD_BITS-1:0] ref_r;
	logic [WORD_BITS-1:0] ncnt_r;
	logic [2:0]           seen_r;
	int                   nbits;
	int                   bad_cnt;
	logic [WORD_BITS:0]   log_q[$];
	wire logic [2:0]      pri_cp = func_r[PRI_CP_LSB_POS +: 3];
	wire logic [2:0]      sec_cp = func_r[SEC_CP_LSB_POS +: 3];
	wire logic [1:0]      presc  = func_r[PRESCALER_POS +: 2];
	wire logic            pd_pol = func_r[PD_POL_POS];
	wire logic            cp_hiz = func_r[CP_TRI_POS];
	initial begin
		seen_r = 3'h0;
		nbits = 0;
		bad_cnt = 0;
	end
	always @(negedge load_enable) begin
		nbits = 0;
	end
	// Shifting runs regardless of the enable pin.
	always @(posedge serial_clock) begin
		shift_r = {shift_r[WORD_BITS-2:0], serial_data};
		nbits = nbits + 1;
	end
	always @(posedge load_enable) begin
		if (nbits > 0) begin
			if (nbits != WORD_BITS) begin
				bad_cnt = bad_cnt + 1;
			end
			log_q.push_back({chip_enable, shift_r});
			case (shift_r[1:0])
				SEL_FUNCTION: begin
					func_r = shift_r;
					seen_r[0] = 1'b1;
				end
				SEL_REFERENCE: begin
					ref_r = shift_r;
					seen_r[1] = 1'b1;
				end
				SEL_N_COUNTER: begin
					ncnt_r = shift_r;
					seen_r[2] = 1'b1;
				end
				default: ;
			endcase
		end
	end
	assign muxed_status_output = chip_enable & (seen_r == 3'h7) & ~func_r[COUNTER_RST_POS];
endmodule : synth_device_model
`default_nettype wire

// ### sim/tb_synth_prog_host.sv
// Purpose: Self-checking bench for the synthesizer programming host.
// Assumes: Device model on the far side logs each latch load.
// Notes:   Inputs change at the falling clock edge.
`timescale 1ns/10ps
`default_nettype none
module tb_synth_prog_host
	import synth_prog_pkg::*;
;
	logic                 clock;
	logic                 rst_n;
	logic                 init_start;
	logic [1:0]           init_method;
	logic [WORD_BITS-1:0] function_word;
	logic [WORD_BITS-1:0] reference_word;
	logic [WORD_BITS-1:0] n_counter_word;
	logic                 single_start;
	logic [WORD_BITS-1:0] single_word;
	logic                 power_down_req;
	logic                 muxed_status_output;
	logic                 busy;
	logic                 init_done;
	logic                 lock_detect;
	logic                 serial_clock;
	logic                 serial_data;
	logic                 load_enable;
	logic                 chip_enable;
	logic [31:0]          rnd;
	int                   n_mismatch;
	int                   n_tests;
	int                   seed;
	int                   base;
	synth_prog_host #(.SETTLE(2)) DUT (.clock(clock), .rst_n(rst_n), .init_start(init_start),
		.init_method(init_method), .function_word(function_word), .reference_word(reference_word),
		.n_counter_word(n_counter_word), .single_start(single_start), .single_word(single_word),
		.power_down_req(power_down_req), .muxed_status_output(muxed_status_output), .busy(busy),
		.init_done(init_done), .lock_detect(lock_detect), .serial_clock(serial_clock),
		.serial_data(serial_data), .load_enable(load_enable), .chip_enable(chip_enable));
	synth_device_model DEV (.serial_clock(serial_clock), .serial_data(serial_data),
		.load_enable(load_enable), .chip_enable(chip_enable), .muxed_status_output(muxed_status_output));
	initial clock = 1'b0;
	always #50 clock = ~clock;
	////////////////////////////////////////////////////////////////////////////
	task automatic end_of_test();
		$display("tests %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : end_of_test
	task automatic chk_word(input logic [WORD_BITS-1:0] got, input logic [WORD_BITS-1:0] exp, input string what);
		n_tests++;
		if (got !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask : chk_word
	task automatic chk_bit(input logic got, input logic exp, input string what);
		n_tests++;
		if (got !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED %0t %s got %b", $time, what, got);
		end
	endtask : chk_bit
	task automatic wait_for(input logic for_done);
		int i;
		i = 0;
		while ((for_done ? init_done : ~busy) !== 1'b1 && i < 3000) begin
			@(negedge clock);
			i++;
		end
		if (i >= 3000) begin
			n_mismatch++;
			$display("CHECK FAILED %0t wait limit", $time);
			end_of_test();
		end
	endtask : wait_for
	// Control bits and the counter reset bit are forced by the host.
	function automatic logic [WORD_BITS-1:0] exp_word(input logic [1:0] m, input int idx);
		logic [WORD_BITS-1:0] f;
		f = {function_word[WORD_BITS-1:3], 3'h2};
		case (idx)
			0: exp_word = (m == METHOD_RESET) ? (f | 24'h000004) : f;
			1: exp_word = {reference_word[WORD_BITS-1:2], 2'h0};
			2: exp_word = {n_counter_word[WORD_BITS-1:2], 2'h1};
			default: exp_word = f;
		endcase
	endfunction : exp_word
	////////////////////////////////////////////////////////////////////////////
	task automatic run_init(input logic [1:0] m);
		int cnt;
		cnt = (m == METHOD_RESET) ? 4 : 3;
		base = DEV.log_q.size();
		init_method = m;
		function_word = 24'($random(seed));
		reference_word = 24'($random(seed));
		n_counter_word = 24'($random(seed));
		single_word = 24'($random(seed));
		init_start = 1'b1;
		@(negedge clock);
		init_start = 1'b0;
		single_start = 1'b1;
		@(negedge clock);
		single_start = 1'b0;
		wait_for(1'b1);
		wait_for(1'b0);
		chk_bit(DEV.log_q.size() == base + cnt, 1'b1, "load count");
		for (int k = 0; k < cnt; k++) begin
			chk_word(DEV.log_q[base + k][WORD_BITS-1:0], exp_word(m, k), "latch word");
			if (m == METHOD_ENABLE) begin
				chk_bit(DEV.log_q[base + k][WORD_BITS], 1'b0, "enable low");
			end
		end
		chk_word(24'({DEV.sec_cp, DEV.pri_cp}), 24'(function_word[20:15]), "currents");
		chk_word(24'(DEV.presc), 24'(function_word[23:22]), "prescaler");
		chk_word(24'({DEV.cp_hiz, DEV.pd_pol}), 24'(function_word[8:7]), "polarity tristate");
		chk_bit(chip_enable, 1'b1, "enable high");
		repeat (4) @(negedge clock);
		chk_bit(lock_detect, 1'b1, "lock");
	endtask : run_init
	task automatic single(input logic [WORD_BITS-1:0] w);
		base = DEV.log_q.size();
		single_word = w;
		single_start = 1'b1;
		@(negedge clock);
		single_start = 1'b0;
		@(negedge clock);
		wait_for(1'b0);
		chk_word(DEV.log_q[base][WORD_BITS-1:0], w, "single word");
	endtask : single
	////////////////////////////////////////////////////////////////////////////
	initial begin
		n_mismatch = 0;
		n_tests = 0;
		seed = 19;
		rst_n = 1'b0;
		init_start = 1'b0;
		init_method = 2'h0;
		function_word = 24'h000000;
		reference_word = 24'h000000;
		n_counter_word = 24'h000000;
		single_start = 1'b0;
		single_word = 24'h000000;
		power_down_req = 1'b0;
		repeat (12) @(negedge clock);
		chk_bit(load_enable, 1'b1, "reset load");
		chk_bit(chip_enable, 1'b0, "reset enable");
		chk_bit(serial_clock, 1'b0, "reset clock");
		chk_bit(busy, 1'b0, "reset busy");
		chk_bit(init_done, 1'b0, "reset done");
		rst_n = 1'b1;
		@(negedge clock);
		for (int m = 0; m < 4; m++) begin
			run_init(2'(m));
		end
		for (int k = 0; k < 4; k++) begin
			rnd = $random(seed);
			single({rnd[23:3], 1'b0, 2'(k)});
		end
		power_down_req = 1'b1;
		repeat (4) @(negedge clock);
		chk_bit(chip_enable, 1'b0, "power down");
		chk_bit(lock_detect, 1'b0, "lock in power down");
		rnd = $random(seed);
		single({rnd[23:2], 2'h1});
		power_down_req = 1'b0;
		repeat (4) @(negedge clock);
		chk_bit(chip_enable, 1'b1, "power up");
		chk_bit(lock_detect, 1'b1, "lock kept");
		chk_bit(DEV.bad_cnt == 0, 1'b1, "bit count");
		end_of_test();
	end
endmodule : tb_synth_prog_host
`default_nettype wire
